// ===== fbd_pkg.sv
// constants and types for the field bus drive slave protocol block
package fbd_pkg;
    localparam int          CLK_HZ          = 125_000_000;
    localparam int          CLK_PERIOD_NS   = 8;

    // bit rates in kbit/s, index is the rate selection code
    localparam int          RATE_500_KBPS   = 500;
    localparam int          RATE_250_KBPS   = 250;
    localparam int          RATE_125_KBPS   = 125;
    localparam int          RATE_75_KBPS    = 75;
    localparam int          RATE_50_KBPS    = 50;
    localparam int          RATE_25_KBPS    = 25;
    localparam logic [2:0]  RATE_SEL_500    = 3'h0;
    localparam logic [2:0]  RATE_SEL_250    = 3'h1;
    localparam logic [2:0]  RATE_SEL_125    = 3'h2;
    localparam logic [2:0]  RATE_SEL_75     = 3'h3;
    localparam logic [2:0]  RATE_SEL_50     = 3'h4;
    localparam logic [2:0]  RATE_SEL_25     = 3'h5;
    localparam logic [2:0]  RATE_SEL_DEFAULT = RATE_SEL_500;
    localparam int          BIT_CNT_W       = 13;
    localparam int          BIT_CYC_25K     = CLK_HZ / (RATE_25_KBPS * 1000);

    // identifiers, 11 bit standard format only
    localparam int          ID_W            = 11;
    localparam int          ADDR_W          = 7;
    localparam logic [10:0] ID_BROADCAST    = 11'h000;
    localparam logic [10:0] ID_CTRL_BASE    = 11'h200;
    localparam logic [10:0] ID_STATUS_BASE  = 11'h180;
    localparam logic [10:0] ID_LOGON_BASE   = 11'h700;

    // broadcast command byte
    localparam logic [7:0]  BC_CMD_START    = 8'h01;
    localparam logic [7:0]  BC_CMD_STOP     = 8'h02;

    // direct mode control word fields
    localparam int          DW_CW_BIT       = 0;
    localparam int          DW_CCW_BIT      = 1;
    localparam int          DW_QSTOP_BIT    = 2;
    localparam int          DW_FRESET_BIT   = 3;
    localparam int          DW_TERM_LSB     = 8;
    localparam int          TERM_W          = 8;

    // profile mode control word fields
    localparam int          PW_SWITCH_ON_BIT = 0;
    localparam int          PW_ENABLE_BIT    = 1;
    localparam int          PW_DIR_CCW_BIT   = 2;
    localparam int          PW_FRESET_BIT    = 7;

    localparam logic        MODE_DIRECT     = 1'b0;
    localparam logic        MODE_PROFILE    = 1'b1;

    // message periods
    localparam int          LOGON_PERIOD_MS  = 100;
    localparam int          STATUS_PERIOD_MS = 10;
    localparam int          LOGON_PERIOD_CYC = LOGON_PERIOD_MS * (CLK_HZ / 1000);
    localparam int          STATUS_PERIOD_CYC = STATUS_PERIOD_MS * (CLK_HZ / 1000);
    localparam int          PER_CNT_W       = 24;

    typedef enum logic [3:0] {
        ST_LOGON   = 4'h1,
        ST_READY   = 4'h2,
        ST_ENABLED = 4'h4,
        ST_FAULT   = 4'h8
    } fbd_state_t;

    // cycles per bit for one selection, the slowest rate passed in
    function automatic logic [12:0] bit_cycles(input logic [2:0] sel, input int cyc_25k);
        int kbps;
        kbps = RATE_500_KBPS;
        unique case (sel)
            RATE_SEL_250: kbps = RATE_250_KBPS;
            RATE_SEL_125: kbps = RATE_125_KBPS;
            RATE_SEL_75:  kbps = RATE_75_KBPS;
            RATE_SEL_50:  kbps = RATE_50_KBPS;
            RATE_SEL_25:  kbps = RATE_25_KBPS;
            default:      kbps = RATE_500_KBPS;
        endcase
        if (sel == RATE_SEL_25) begin
            return cyc_25k[12:0];
        end
        return 13'(CLK_HZ / (kbps * 1000));
    endfunction

    function automatic logic [10:0] addr_id(input logic [10:0] base, input logic [6:0] addr);
        return 11'(base + {4'h0, addr});
    endfunction
endpackage

// ===== fbd_rate_div.sv
// bit time divider giving a one cycle tick at the selected bus rate
`timescale 1ns/10ps
module fbd_rate_div
    import fbd_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic [BIT_CNT_W-1:0] div_cyc,
    output logic                      tick
);
    logic [BIT_CNT_W-1:0] cnt_q;
    logic [BIT_CNT_W-1:0] cnt_d;
    logic                 tick_q;
    logic                 tick_d;

    always_comb begin
        tick_d = 1'b0;
        if (cnt_q >= BIT_CNT_W'(div_cyc - 13'h0001)) begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d = BIT_CNT_W'(cnt_q + 13'h0001);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule

// ===== fbd_drive_slave.sv
// drive slave protocol engine: identifiers, logon, status, device state, control modes
`timescale 1ns/10ps
module fbd_drive_slave
    import fbd_pkg::*;
#(
    parameter int LOGON_CYC  = LOGON_PERIOD_CYC,
    parameter int STATUS_CYC = STATUS_PERIOD_CYC,
    parameter int CYC_25K    = BIT_CYC_25K
)
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic [2:0]        rate_sel,
    output logic                   bit_tick,
    input  wire logic [ADDR_W-1:0] dev_addr,
    input  wire logic              ctrl_mode,
    input  wire logic              rx_valid,
    input  wire logic [ID_W-1:0]   rx_id,
    input  wire logic              rx_ext,
    input  wire logic [15:0]       rx_data,
    output logic                   tx_valid,
    input  wire logic              tx_ready,
    output logic [ID_W-1:0]        tx_id,
    output logic [15:0]            tx_data,
    input  wire logic              app_error,
    input  wire logic [TERM_W-1:0] term_handover,
    input  wire logic [TERM_W-1:0] local_term_in,
    output logic [TERM_W-1:0]      term_out,
    output logic                   start_clockwise_function,
    output logic                   start_anticlockwise_function,
    output logic                   quick_stop,
    output logic [3:0]             dev_state
);
    fbd_state_t            state_q, state_d;
    logic                  started_q, started_d;
    logic                  bus_run_q, bus_run_d;
    logic [15:0]           word_q, word_d;
    logic [PER_CNT_W-1:0]  per_q, per_d;
    logic                  tx_valid_q, tx_valid_d;
    logic [ID_W-1:0]       tx_id_q, tx_id_d;
    logic [15:0]           tx_data_q, tx_data_d;
    logic                  run_cw_q, run_cw_d;
    logic                  run_ccw_q, run_ccw_d;
    logic                  qstop_q, qstop_d;
    logic [TERM_W-1:0]     term_q, term_d;

    logic                  std_frame;
    logic                  hit_ctrl;
    logic                  hit_bcast;
    logic                  ctrl_reset;
    logic                  ctrl_run;
    logic [PER_CNT_W-1:0]  per_len;

    fbd_rate_div u_rate_div (
        .clk     (clk),
        .arst_n  (arst_n),
        .div_cyc (bit_cycles(rate_sel, CYC_25K)),
        .tick    (bit_tick)
    );

    // frame acceptance
    assign std_frame = rx_valid && !rx_ext;
    assign hit_ctrl  = std_frame && (rx_id == addr_id(ID_CTRL_BASE, dev_addr));
    assign hit_bcast = std_frame && (rx_id == ID_BROADCAST);

    // decode of a received control word according to the active mode
    always_comb begin
        if (ctrl_mode == MODE_DIRECT) begin
            ctrl_reset = rx_data[DW_FRESET_BIT];
            ctrl_run   = rx_data[DW_CW_BIT] || rx_data[DW_CCW_BIT];
        end else begin
            ctrl_reset = rx_data[PW_FRESET_BIT];
            // operation enabled only reachable through switched on
            ctrl_run   = rx_data[PW_SWITCH_ON_BIT] && rx_data[PW_ENABLE_BIT];
        end
    end

    assign per_len = started_q ? PER_CNT_W'(STATUS_CYC - 1) : PER_CNT_W'(LOGON_CYC - 1);

    // protocol and device state
    always_comb begin
        state_d    = state_q;
        started_d  = started_q;
        bus_run_d  = bus_run_q;
        word_d     = word_q;
        per_d      = per_q;
        tx_valid_d = tx_valid_q;
        tx_id_d    = tx_id_q;
        tx_data_d  = tx_data_q;

        if (hit_bcast) begin
            if (rx_data[7:0] == BC_CMD_START) begin
                bus_run_d = 1'b1;
                started_d = 1'b1;
                if (state_q == ST_LOGON) begin
                    state_d = ST_READY;
                end
            end else if (rx_data[7:0] == BC_CMD_STOP) begin
                bus_run_d = 1'b0;
            end
        end

        if (hit_ctrl && started_q) begin
            word_d = rx_data;
            unique case (state_q)
                ST_READY: begin
                    if (ctrl_run) begin
                        state_d = ST_ENABLED;
                    end
                end
                ST_ENABLED: begin
                    if (!ctrl_run) begin
                        state_d = ST_READY;
                    end
                end
                ST_FAULT: begin
                    if (ctrl_reset) begin
                        state_d = ST_READY;
                    end
                end
                ST_LOGON: begin
                    state_d = ST_LOGON;
                end
            endcase
        end

        if (app_error) begin
            state_d = ST_FAULT;
            word_d  = '0;
        end

        // periodic message: logon before system start, status after
        if (tx_valid_q && tx_ready) begin
            tx_valid_d = 1'b0;
        end
        if (per_q == '0) begin
            per_d = per_len;
            if (!tx_valid_q || tx_ready) begin
                tx_valid_d = 1'b1;
                if (started_q) begin
                    tx_id_d   = addr_id(ID_STATUS_BASE, dev_addr);
                    tx_data_d = {3'h0, bus_run_q, state_q, word_q[7:0]};
                end else begin
                    tx_id_d   = addr_id(ID_LOGON_BASE, dev_addr);
                    tx_data_d = {9'h000, dev_addr};
                end
            end
        end else begin
            per_d = PER_CNT_W'(per_q - 24'h000001);
        end
        if (started_d && !started_q) begin
            per_d = '0;  // first status message follows at once
        end
    end

    // drive function outputs
    always_comb begin
        run_cw_d  = 1'b0;
        run_ccw_d = 1'b0;
        qstop_d   = 1'b0;
        term_d    = local_term_in;
        if (state_q == ST_ENABLED && bus_run_q) begin
            if (ctrl_mode == MODE_DIRECT) begin
                run_cw_d  = word_q[DW_CW_BIT];
                run_ccw_d = word_q[DW_CCW_BIT] && !word_q[DW_CW_BIT];
            end else begin
                run_cw_d  = !word_q[PW_DIR_CCW_BIT];
                run_ccw_d = word_q[PW_DIR_CCW_BIT];
            end
        end
        if (ctrl_mode == MODE_DIRECT) begin
            qstop_d = word_q[DW_QSTOP_BIT];
            term_d  = (word_q[DW_TERM_LSB +: TERM_W] & term_handover)
                    | (local_term_in & ~term_handover);
        end
        if (state_q == ST_FAULT) begin
            qstop_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q    <= ST_LOGON;
            started_q  <= 1'b0;
            bus_run_q  <= 1'b0;
            word_q     <= '0;
            per_q      <= '0;
            tx_valid_q <= 1'b0;
            tx_id_q    <= '0;
            tx_data_q  <= '0;
            run_cw_q   <= 1'b0;
            run_ccw_q  <= 1'b0;
            qstop_q    <= 1'b0;
            term_q     <= '0;
        end else begin
            state_q    <= state_d;
            started_q  <= started_d;
            bus_run_q  <= bus_run_d;
            word_q     <= word_d;
            per_q      <= per_d;
            tx_valid_q <= tx_valid_d;
            tx_id_q    <= tx_id_d;
            tx_data_q  <= tx_data_d;
            run_cw_q   <= run_cw_d;
            run_ccw_q  <= run_ccw_d;
            qstop_q    <= qstop_d;
            term_q     <= term_d;
        end
    end

    assign tx_valid                     = tx_valid_q;
    assign tx_id                        = tx_id_q;
    assign tx_data                      = tx_data_q;
    assign start_clockwise_function     = run_cw_q;
    assign start_anticlockwise_function = run_ccw_q;
    assign quick_stop                   = qstop_q;
    assign term_out                     = term_q;
    assign dev_state                    = state_q;
endmodule

// ===== fbd_drive_slave_asserts.sv
// port checker for the drive slave protocol engine
`timescale 1ns/10ps
module fbd_drive_slave_asserts
    import fbd_pkg::*;
#(
    parameter int CYC_25K = BIT_CYC_25K
)
(
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic [2:0]        rate_sel,
    input wire logic              bit_tick,
    input wire logic [ADDR_W-1:0] dev_addr,
    input wire logic              rx_valid,
    input wire logic [ID_W-1:0]   rx_id,
    input wire logic              rx_ext,
    input wire logic              tx_valid,
    input wire logic              tx_ready,
    input wire logic [ID_W-1:0]   tx_id,
    input wire logic [15:0]       tx_data,
    input wire logic              app_error,
    input wire logic              start_clockwise_function,
    input wire logic              start_anticlockwise_function,
    input wire logic              quick_stop,
    input wire logic [3:0]        dev_state
);
    logic [12:0] gap_q;
    logic [12:0] gap_exp;
    logic [2:0]  rsel_q;
    logic        armed_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    always_comb begin
        case (rsel_q)
            3'h1:    gap_exp = 13'h1F4;
            3'h2:    gap_exp = 13'h3E8;
            3'h3:    gap_exp = 13'h682;
            3'h4:    gap_exp = 13'h9C4;
            3'h5:    gap_exp = 13'(CYC_25K);
            default: gap_exp = 13'h0FA;
        endcase
    end
    // gap is only judged between two ticks of one unchanged rate
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_q   <= 13'h0;
            rsel_q  <= 3'h0;
            armed_q <= 1'b0;
        end else begin
            gap_q   <= bit_tick ? 13'h1 : gap_q + 13'h1;
            rsel_q  <= rate_sel;
            armed_q <= (rsel_q == rate_sel) && (armed_q || bit_tick);
        end
    end
    sequence seq_sys_start;
        dev_state == 4'h1 ##1 dev_state == 4'h2;
    endsequence
    sequence seq_status_out;
        tx_valid && tx_id == ID_STATUS_BASE + 11'(dev_addr);
    endsequence
    a_tick_gap: assert property (bit_tick && armed_q |-> gap_q == gap_exp)
        else $error("bit tick spacing wrong");
    a_tx_stands: assert property (tx_valid && !tx_ready
        |=> tx_valid && $stable(tx_id) && $stable(tx_data))
        else $error("message changed before acceptance");
    a_logon_id: assert property ($rose(tx_valid) && dev_state == 4'h1
        |-> tx_id == ID_LOGON_BASE + 11'(dev_addr))
        else $error("logon id wrong");
    a_start_status: assert property (seq_sys_start |-> ##[1:40] seq_status_out)
        else $error("no status message after start");
    a_frame_ignored: assert property (rx_valid && !app_error && (rx_ext
        || (rx_id != ID_BROADCAST && rx_id != ID_CTRL_BASE + 11'(dev_addr)))
        |=> $stable(dev_state))
        else $error("ignored frame moved state");
    a_error_fault: assert property (app_error |=> dev_state == 4'h8)
        else $error("error did not force fault");
    a_fault_drive: assert property (dev_state == 4'h8
        |=> quick_stop && !start_clockwise_function && !start_anticlockwise_function)
        else $error("fault left drive running");
    a_cw_cause: assert property (start_clockwise_function
        |-> $past(dev_state) == 4'h4 && !start_anticlockwise_function)
        else $error("clockwise start without enabled state");
endmodule

// ===== fbd_master_model.sv
// master controller model: sends frames, takes messages
`timescale 1ns/10ps
module fbd_master_model
    import fbd_pkg::*;
#(
    parameter int MSG_GAP = 125_000
)
(
    input  wire logic            clk,
    input  wire logic            arst_n,
    output logic                 rx_valid,
    output logic [ID_W-1:0]      rx_id,
    output logic                 rx_ext,
    output logic [15:0]          rx_data,
    input  wire logic            tx_valid,
    output logic                 tx_ready,
    input  wire logic [ID_W-1:0] tx_id,
    input  wire logic [15:0]     tx_data
);
    int          stall = 0;
    int          wait_n = 0;
    int          msg_count = 0;
    logic [10:0] last_id = 11'h0;
    logic [15:0] last_data = 16'h0;
    initial begin
        rx_valid = 1'b0;
        rx_id    = 11'h7FF;
        rx_ext   = 1'b0;
        rx_data  = 16'hFFFF;
    end
    // one master, one address per slave, words given in profile order
    task automatic send(input logic [10:0] id, input logic ext, input logic [15:0] w);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_id    <= id;
        rx_ext   <= ext;
        rx_data  <= w;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_id    <= ~id;
        rx_data  <= ~w;
        repeat (MSG_GAP) @(posedge clk);
    endtask
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_ready <= 1'b0;
            wait_n   <= 0;
        end else if (tx_valid && !tx_ready) begin
            wait_n   <= wait_n + 1;
            tx_ready <= (wait_n >= stall);
        end else begin
            tx_ready <= 1'b0;
            wait_n   <= 0;
            if (tx_valid && tx_ready) begin
                msg_count <= msg_count + 1;
                last_id   <= tx_id;
                last_data <= tx_data;
            end
        end
    end
endmodule

// ===== test_fbd_drive_slave.sv
// self-checking bench for the drive slave protocol engine
`timescale 1ns/10ps
module test_fbd_drive_slave
    import fbd_pkg::*;
;
    localparam logic [6:0] ADDR = 7'h15;
    logic        clk;
    logic        arst_n;
    logic [2:0]  rate_sel;
    logic        bit_tick;
    logic [6:0]  dev_addr;
    logic        ctrl_mode;
    logic        rx_valid;
    logic [10:0] rx_id;
    logic        rx_ext;
    logic [15:0] rx_data;
    logic        tx_valid;
    logic        tx_ready;
    logic [10:0] tx_id;
    logic [15:0] tx_data;
    logic        app_error;
    logic [7:0]  term_handover;
    logic [7:0]  local_term_in;
    logic [7:0]  term_out;
    logic        start_clockwise_function;
    logic        start_anticlockwise_function;
    logic        quick_stop;
    logic [3:0]  dev_state;
    int          err_count = 0;
    int          samples_checked = 0;
    fbd_drive_slave #(.LOGON_CYC(50), .STATUS_CYC(30), .CYC_25K(20)) dut_u (.clk, .arst_n,
        .rate_sel, .bit_tick, .dev_addr, .ctrl_mode, .rx_valid, .rx_id, .rx_ext, .rx_data,
        .tx_valid, .tx_ready, .tx_id, .tx_data, .app_error, .term_handover, .local_term_in,
        .term_out, .start_clockwise_function, .start_anticlockwise_function, .quick_stop,
        .dev_state);
    fbd_master_model #(.MSG_GAP(8)) mdl_u (.clk, .arst_n, .rx_valid, .rx_id, .rx_ext,
        .rx_data, .tx_valid, .tx_ready, .tx_id, .tx_data);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic [15:0] drv();
        return {13'h0, quick_stop, start_anticlockwise_function, start_clockwise_function};
    endfunction
    task automatic ctl(input logic [15:0] w);
        mdl_u.send(ID_CTRL_BASE + 11'(ADDR), 1'b0, w);
    endtask
    task automatic wait_msgs(input int n);
        int t = 0;
        n = n + mdl_u.msg_count;
        while (mdl_u.msg_count < n && t < 2000) begin
            @(posedge clk);
            t++;
        end
        if (t >= 2000) begin
            err_count++;
            $display("FAIL message count expected %0d seen %0d", n, mdl_u.msg_count);
        end
    endtask
    task automatic sc_logon;
        wait_msgs(2);
        chk("logon id", 16'(ID_LOGON_BASE + 11'(ADDR)), 16'(mdl_u.last_id));
        chk("logon data", {9'h0, ADDR}, mdl_u.last_data);
        dev_addr <= 7'h2A;
        mdl_u.stall = 6;
        wait_msgs(2);
        chk("moved id", 16'(ID_LOGON_BASE + 11'h02A), 16'(mdl_u.last_id));
        dev_addr <= ADDR;
        mdl_u.stall = 0;
        wait_msgs(2);
    endtask
    task automatic sc_start;
        mdl_u.send(ID_BROADCAST, 1'b1, 16'(BC_CMD_START));
        mdl_u.send(ID_CTRL_BASE + 11'(ADDR) + 11'h001, 1'b0, 16'h0001);
        ctl(16'h0001);
        chk("state held", 16'h0001, 16'(dev_state));
        mdl_u.send(ID_BROADCAST, 1'b0, 16'(BC_CMD_START));
        chk("ready", 16'h0002, 16'(dev_state));
        wait_msgs(1);
        chk("status id", 16'(ID_STATUS_BASE + 11'(ADDR)), 16'(mdl_u.last_id));
        chk("status bits", 16'h0012, 16'(mdl_u.last_data[12:8]));
    endtask
    task automatic sc_direct;
        logic [15:0] w[4] = '{16'hC301, 16'h0003, 16'h0002, 16'h5A04};
        logic [15:0] e[4] = '{16'h0001, 16'h0001, 16'h0002, 16'h0004};
        term_handover <= 8'h0F;
        local_term_in <= 8'hA5;
        foreach (w[i]) begin
            ctl(w[i]);
            chk("drive", e[i], drv());
        end
        chk("terminals", 16'h00AA, 16'(term_out));
        ctl(16'h0001);
        mdl_u.send(ID_BROADCAST, 1'b0, 16'(BC_CMD_STOP));
        chk("stopped", 16'h0000, drv());
        mdl_u.send(ID_BROADCAST, 1'b0, 16'h0055);
        chk("unknown command", 16'h0000, drv());
        mdl_u.send(ID_BROADCAST, 1'b0, 16'(BC_CMD_START));
        ctl(16'h0001);
        chk("restart", 16'h0001, drv());
    endtask
    task automatic sc_fault;
        app_error <= 1'b1;
        repeat (3) @(posedge clk);
        chk("fault", 16'h0008, 16'(dev_state));
        chk("fault drive", 16'h0004, drv());
        app_error <= 1'b0;
        ctl(16'h0001);
        chk("fault held", 16'h0008, 16'(dev_state));
        ctl(16'h0008);
        chk("fault left", 16'h0000, 16'(dev_state == 4'h8));
        ctrl_mode <= MODE_PROFILE;
        ctl(16'h0001);
        chk("switched on", 16'h0000, 16'(dev_state == 4'h4));
        ctl(16'h0003);
        chk("profile run", 16'h0001, drv());
        ctl(16'h0007);
        chk("profile ccw", 16'h0002, drv());
        app_error <= 1'b1;
        @(posedge clk);
        app_error <= 1'b0;
        ctl(16'h0080);
        chk("profile reset", 16'h0002, 16'(dev_state));
    endtask
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (bit_tick !== 1'b1 && n < 4000);
    endtask
    task automatic sc_rate;
        int exp[7] = '{250, 500, 1000, 1666, 2500, 20, 250};
        int n;
        for (int s = 0; s < 7; s++) begin
            @(posedge clk);
            rate_sel <= 3'(s);
            wait_tick(n);
            wait_tick(n);
            chk("tick gap", 16'(exp[s]), 16'(n));
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        arst_n        = 1'b0;
        rate_sel      = RATE_SEL_DEFAULT;
        dev_addr      = ADDR;
        ctrl_mode     = MODE_DIRECT;
        app_error     = 1'b0;
        term_handover = 8'h00;
        local_term_in = 8'h00;
        repeat (6) @(posedge clk);
        chk("reset state", 16'h0001, 16'(dev_state));
        arst_n <= 1'b1;
        sc_logon();
        sc_start();
        sc_direct();
        sc_fault();
        sc_rate();
        print_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        print_verdict();
    end
endmodule
bind fbd_drive_slave fbd_drive_slave_asserts #(.CYC_25K(CYC_25K)) chk_u (.clk, .arst_n,
    .rate_sel, .bit_tick, .dev_addr, .rx_valid, .rx_id, .rx_ext, .tx_valid, .tx_ready,
    .tx_id, .tx_data, .app_error, .start_clockwise_function, .start_anticlockwise_function,
    .quick_stop, .dev_state);
